// File: hdl/adcct_conv_timing.sv
// Functional notes
// - Modulator clock is oscillator divided by four
// - Oscillator 1.024 MHz normal, 2.048 MHz turbo
// - One settled result per conversion, none discarded
// - First conversion lead 28.5 or 105 cycles
// - Continuous period per rate, both modes
// - Normal single-shot start-to-ready per rate
// - Turbo single-shot start-to-ready per rate
// - Command latched at its bus acceptance point
// - Two-bit reference select, internal by default
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcct_regs.svh"
module adcct_conv_timing #(
    parameter int REF_SETTLE_NS = `ADCCT_REF_SETTLE_NS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire adcct_pkg::adcct_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic result_ready_n,
    output logic conv_done,
    output logic modulator_clk,
    output logic [2:0] rate_sel,
    output logic [1:0] ref_sel,
    output logic turbo_mode,
    output logic ref_settled
);
    import adcct_pkg::*;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    // Least settling time, rounded up
    localparam int SETTLE_CYC = (REF_SETTLE_NS + `ADCCT_CLK_NS - 1) / `ADCCT_CLK_NS;
    localparam logic [15:0] SETTLE_LD = 16'(SETTLE_CYC);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    adcct_ctrl_t ctrl; // Stored control
    adcct_ctrl_t next_ctrl; // Control after a write
    adcct_state_t state; // Sequencer state
    logic ack; // Bus answer phase
    logic [15:0] phase; // Oscillator phase accumulator
    logic half_tick; // One half oscillator period
    logic [2:0] mod_cnt; // Modulator divider
    logic [17:0] cnt; // Remaining half periods
    logic rdy_n; // Ready level
    logic done_q; // Completion strobe
    logic [15:0] settle_cnt; // Reference settling count
    logic [1:0] irq_stat; // Sticky events
    logic [1:0] irq_mask; // Event enables

    // ----------------------------------------
    // Length lookup
    // ----------------------------------------
    // Continuous period in oscillator cycles
    function automatic logic [16:0] cont_len(input logic [2:0] r);
        logic [16:0] v;
        v = `ADCCT_CONT_6;
        unique case (r)
            3'h0: v = `ADCCT_CONT_0;
            3'h1: v = `ADCCT_CONT_1;
            3'h2: v = `ADCCT_CONT_2;
            3'h3: v = `ADCCT_CONT_3;
            3'h4: v = `ADCCT_CONT_4;
            3'h5: v = `ADCCT_CONT_5;
            default: v = `ADCCT_CONT_6; // Code 7 acts as fastest
        endcase
        return v;
    endfunction : cont_len

    // Single-shot delay from latch, in oscillator cycles
    function automatic logic [16:0] ss_len(input logic [2:0] r, input logic t);
        logic [16:0] e;
        e = `ADCCT_SS_EXTRA_NRM;
        if (t) begin
            e = (r == 3'h0) ? `ADCCT_SS_EXTRA_TRB0 : `ADCCT_SS_EXTRA_TRB;
        end
        return 17'(cont_len(r) + e);
    endfunction : ss_len

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire req = avs_req.read | avs_req.write;
    // One wait state, then the answer
    assign avs_waitrequest = req & ~ack;
    wire wr_acc = avs_req.write & ack & ce;
    wire sel_ctrl = avs_req.address == `ADCCT_OFS_CTRL;
    wire sel_stat = avs_req.address == `ADCCT_OFS_STAT;
    wire sel_istat = avs_req.address == `ADCCT_OFS_ISTAT;
    wire sel_imask = avs_req.address == `ADCCT_OFS_IMASK;
    wire wr_ctrl = wr_acc & sel_ctrl;
    wire [31:0] wd = avs_req.writedata;

    // Fields as written
    assign next_ctrl.pwdn = wd[`ADCCT_B_PWDN];
    assign next_ctrl.vref = wd[`ADCCT_VREF_HI:`ADCCT_VREF_LO];
    assign next_ctrl.rate = wd[`ADCCT_RATE_HI:`ADCCT_RATE_LO];
    assign next_ctrl.turbo = wd[`ADCCT_B_TURBO];
    assign next_ctrl.cont = wd[`ADCCT_B_CONT];

    // latch at acceptance
    // Start bit is a command, never stored; ignored when the same write sets power-down
    wire start_cmd = wr_ctrl & wd[`ADCCT_B_START] & ~next_ctrl.pwdn;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] rd_ctrl = {23'h0, ctrl.pwdn, ctrl.vref, ctrl.rate, ctrl.turbo,
        ctrl.cont, 1'b0};
    wire [31:0] rd_stat = {29'h0, ref_settled, rdy_n, state != ADCCT_IDLE};
    // Unmapped offsets read as zero
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
        sel_stat ? rd_stat :
        sel_istat ? {30'h0, irq_stat} :
        sel_imask ? {30'h0, irq_mask} : 32'h0;

    // Answer timing and registered read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0;
        end else if (ce) begin
            ack <= req & ~ack;
            avs_readdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // internal by default
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= '{pwdn: 1'b0, vref: `ADCCT_VREF_INT, rate: 3'h0,
                turbo: 1'b0, cont: 1'b0};
        end else if (ce && wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    assign ref_sel = ctrl.vref;
    assign rate_sel = ctrl.rate;
    assign turbo_mode = ctrl.turbo;

    // ----------------------------------------
    // Internal oscillator
    // ----------------------------------------
    // mode sets rate
    // Half-period ticks from a fractional accumulator: jitter is one
    // system clock, the average rate is exact
    wire [16:0] inc = ctrl.turbo ? `ADCCT_HALF_KHZ_TRB : `ADCCT_HALF_KHZ_NRM;
    wire [16:0] phase_sum = {1'b0, phase} + inc;
    wire wrap = phase_sum >= `ADCCT_CLK_KHZ;
    wire [16:0] phase_red = phase_sum - `ADCCT_CLK_KHZ;
    wire [15:0] next_phase = wrap ? phase_red[15:0] : phase_sum[15:0];

    // Accumulator and tick
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= 16'h0;
            half_tick <= 1'b0;
        end else if (ce) begin
            phase <= next_phase;
            half_tick <= wrap;
        end
    end

    // divide by four
    // Eight half periods make one modulator period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mod_cnt <= 3'h0;
        end else if (ce && half_tick) begin
            mod_cnt <= (mod_cnt == `ADCCT_MOD_HALVES) ? 3'h0 : 3'(mod_cnt + 3'h1);
        end
    end
    assign modulator_clk = mod_cnt[2];

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    // period per rate
    wire [17:0] cont2 = {cont_len(ctrl.rate), 1'b0};
    wire [17:0] ss2 = {ss_len(next_ctrl.rate, next_ctrl.turbo), 1'b0};
    wire [17:0] lead2 = next_ctrl.turbo ? `ADCCT_LEAD2_TRB : `ADCCT_LEAD2_NRM;
    wire last = half_tick && (cnt == 18'h1);
    wire mid = half_tick && (cnt == {1'b0, cont2[17:1]});

    // Sequencer: restart on any start, abort on power-down
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ADCCT_IDLE;
            cnt <= 18'h0;
        end else if (ce) begin
            if (start_cmd) begin
                state <= next_ctrl.cont ? ADCCT_LEAD : ADCCT_CONV;
                cnt <= next_ctrl.cont ? lead2 : ss2;
            end else if (ctrl.pwdn) begin
                state <= ADCCT_IDLE;
            end else begin
                unique case (state)
                    ADCCT_IDLE: begin
                        cnt <= 18'h0;
                    end
                    ADCCT_LEAD: begin
                        if (last) begin
                            state <= ADCCT_CONV;
                            cnt <= cont2;
                        end else if (half_tick) begin
                            cnt <= 18'(cnt - 18'h1);
                        end
                    end
                    ADCCT_CONV: begin
                        if (last) begin
                            state <= ctrl.cont ? ADCCT_CONV : ADCCT_IDLE;
                            cnt <= ctrl.cont ? cont2 : 18'h0;
                        end else if (half_tick) begin
                            cnt <= 18'(cnt - 18'h1);
                        end
                    end
                    default: begin
                        state <= ADCCT_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Ready and completion
    // ----------------------------------------
    wire conv_end = (state == ADCCT_CONV) && last && !ctrl.pwdn && !start_cmd;

    // falls at completion
    // Rises on a new start and mid-conversion, so every result shows a fresh
    // falling edge, also the last one after continuous mode is switched off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdy_n <= 1'b1;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= conv_end;
            if (conv_end) begin
                rdy_n <= 1'b0;
            end else if (start_cmd || (state == ADCCT_CONV && mid)) begin
                rdy_n <= 1'b1;
            end
        end
    end
    assign result_ready_n = rdy_n;
    // one settled result
    // Filter output strobe once per conversion; nothing dropped
    assign conv_done = done_q;

    // ----------------------------------------
    // Reference settling
    // ----------------------------------------
    wire leave_pd = wr_ctrl & ctrl.pwdn & ~next_ctrl.pwdn;
    wire to_int = wr_ctrl && ctrl.vref == `ADCCT_VREF_EXT &&
        next_ctrl.vref == `ADCCT_VREF_INT;

    // settle time shown
    // Counted after power-down exit and external-to-internal switch; reset loads zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            settle_cnt <= 16'h0;
        end else if (ce) begin
            if (leave_pd || to_int) begin
                settle_cnt <= SETTLE_LD;
            end else if (settle_cnt != 16'h0) begin
                settle_cnt <= 16'(settle_cnt - 16'h1);
            end
        end
    end
    // Reset is not counted: only the first cycle after release reads as unsettled
    logic boot; // First cycle after reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot <= 1'b1;
        end else if (ce) begin
            boot <= 1'b0;
        end
    end
    assign ref_settled = (settle_cnt == 16'h0) && !boot;
    wire settle_evt = settle_cnt == 16'h1;

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [1:0] irq_set = {settle_evt, conv_end};
    wire [1:0] irq_clr = (wr_acc & sel_istat) ? wd[1:0] : 2'h0;

    // Sticky bits, write one clears, a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end else if (ce) begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            if (wr_acc && sel_imask) begin
                irq_mask <= wd[1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

endmodule : adcct_conv_timing
`default_nettype wire

// File: hdl/adcct_regs.svh
`ifndef ADCCT_REGS_SVH
`define ADCCT_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADCCT_OFS_CTRL 4'h0
`define ADCCT_OFS_STAT 4'h4
`define ADCCT_OFS_ISTAT 4'h8
`define ADCCT_OFS_IMASK 4'hc
// ----------------------------------------
// Control fields
// ----------------------------------------
`define ADCCT_B_START 0
`define ADCCT_B_CONT 1
`define ADCCT_B_TURBO 2
`define ADCCT_RATE_LO 3
`define ADCCT_RATE_HI 5
`define ADCCT_VREF_LO 6
`define ADCCT_VREF_HI 7
`define ADCCT_B_PWDN 8
`define ADCCT_VREF_INT 2'h0
`define ADCCT_VREF_EXT 2'h1
// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define ADCCT_B_BUSY 0
`define ADCCT_B_RDYN 1
`define ADCCT_B_SETTLED 2
`define ADCCT_IRQ_DONE 0
`define ADCCT_IRQ_REF 1
// ----------------------------------------
// Timing: rates in kHz, modulator and lead in half oscillator cycles, times in ns
// ----------------------------------------
`define ADCCT_CLK_KHZ 17'h09c40
`define ADCCT_HALF_KHZ_NRM 17'h00800
`define ADCCT_HALF_KHZ_TRB 17'h01000
`define ADCCT_MOD_HALVES 3'h7
`define ADCCT_LEAD2_NRM 18'h00039
`define ADCCT_LEAD2_TRB 18'h000d2
`define ADCCT_REF_SETTLE_NS 25000
`define ADCCT_CLK_NS 25
// ----------------------------------------
// Conversion lengths in oscillator cycles
// ----------------------------------------
`define ADCCT_CONT_0 17'h0c7f8
`define ADCCT_CONT_1 17'h058fc
`define ADCCT_CONT_2 17'h02d0c
`define ADCCT_CONT_3 17'h0171c
`define ADCCT_CONT_4 17'h00c2c
`define ADCCT_CONT_5 17'h006bc
`define ADCCT_CONT_6 17'h0040c
`define ADCCT_SS_EXTRA_NRM 17'h00019
`define ADCCT_SS_EXTRA_TRB 17'h0001d
`define ADCCT_SS_EXTRA_TRB0 17'h00019
`endif

// File: hdl/adcct_pkg.sv
// ----------------------------------------
// Shared types of the timing block
// ----------------------------------------
package adcct_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ADCCT_IDLE = 2'b00,
        ADCCT_LEAD = 2'b01,
        ADCCT_CONV = 2'b10
    } adcct_state_t;
    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } adcct_avs_req_t;
    // Stored control fields
    typedef struct packed {
        logic pwdn;
        logic [1:0] vref;
        logic [2:0] rate;
        logic turbo;
        logic cont;
    } adcct_ctrl_t;
endpackage : adcct_pkg

// File: sim/adcct_conv_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker of the conversion timer
// ----------------------------------------
module adcct_conv_timing_props
    import adcct_pkg::*;
#(
    parameter int REF_SETTLE_NS = 25000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire adcct_pkg::adcct_avs_req_t avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic result_ready_n,
    input wire logic conv_done,
    input wire logic modulator_clk,
    input wire logic [2:0] rate_sel,
    input wire logic [1:0] ref_sel,
    input wire logic turbo_mode,
    input wire logic ref_settled
);
    // Least settle time in clocks, rounded up
    localparam int SETTLE_CYC = (REF_SETTLE_NS + 24) / 25;
    logic [15:0] low_cnt; // Clocks with reference unsettled
    logic mod_q; // Last modulator level
    logic trb_q; // Last mode
    logic armed; // Interval ran in one mode only
    logic toggle; // Modulator edge seen
    logic [7:0] hold; // Clocks since last edge
    assign toggle = modulator_clk != mod_q;
    // Interval timer; a mode switch spoils one interval, so skip it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mod_q <= 1'b0;
            trb_q <= 1'b0;
            armed <= 1'b0;
            hold <= 8'h00;
        end else begin
            mod_q <= modulator_clk;
            trb_q <= turbo_mode;
            armed <= (toggle | armed) & (turbo_mode == trb_q);
            hold <= toggle ? 8'h01 : hold + {7'h00, hold != 8'hff};
        end
    end
    // Unsettled run length; reset counts as already settled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            low_cnt <= 16'(SETTLE_CYC);
        end else begin
            low_cnt <= ref_settled ? 16'h0000 : 16'(low_cnt + 16'h0001);
        end
    end
    chk_one_wait: assert property (@(posedge clk) disable iff (!nrst)
        (avs_req.read | avs_req.write) && avs_waitrequest && ce |=> !avs_waitrequest)
        else $error("waitrequest held past one wait state");
    chk_no_stall: assert property (@(posedge clk) disable iff (!nrst)
        !(avs_req.read | avs_req.write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    chk_done_cause: assert property (@(posedge clk) disable iff (!nrst)
        conv_done |-> !result_ready_n && $past(result_ready_n))
        else $error("done pulse without ready fall");
    chk_done_once: assert property (@(posedge clk) disable iff (!nrst)
        $fell(result_ready_n) |-> conv_done ##1 !conv_done)
        else $error("done pulse missing or long");
    chk_mod_period: assert property (@(posedge clk) disable iff (!nrst)
        toggle && armed && turbo_mode == trb_q |->
        (turbo_mode ? (hold >= 8'd37 && hold <= 8'd41) : (hold >= 8'd76 && hold <= 8'd80)))
        else $error("modulator half period off");
    chk_ref_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> ref_sel == 2'h0 && rate_sel == 3'h0 && !turbo_mode)
        else $error("control fields not cleared by reset");
    chk_ctrl_write: assert property (@(posedge clk) disable iff (!nrst)
        !$stable({rate_sel, ref_sel, turbo_mode}) |-> $past(avs_req.write))
        else $error("control field moved without write");
    chk_ref_settle: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ref_settled) |-> low_cnt >= 16'(SETTLE_CYC))
        else $error("reference settle time off");
    chk_irq_clear: assert property (@(posedge clk) disable iff (!nrst)
        $fell(irq) |-> $past(avs_req.write))
        else $error("interrupt dropped without write");
endmodule : adcct_conv_timing_props
bind adcct_conv_timing adcct_conv_timing_props #(.REF_SETTLE_NS(REF_SETTLE_NS)) i_props (
    .clk(clk), .nrst(nrst), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .result_ready_n(result_ready_n),
    .conv_done(conv_done), .modulator_clk(modulator_clk), .rate_sel(rate_sel),
    .ref_sel(ref_sel), .turbo_mode(turbo_mode), .ref_settled(ref_settled));
`default_nettype wire

// File: sim/adcct_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host model: bus master and settle wait
// ----------------------------------------
module adcct_host
    import adcct_pkg::*;
(
    input wire logic clk,
    output var adcct_pkg::adcct_avs_req_t req,
    input wire logic [31:0] rdata,
    input wire logic waitreq,
    input wire logic settled
);
    initial req = '0;
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        // No cycle count assumed: only the bench watchdog ends this wait
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        req <= '0;
        @(posedge clk);
    endtask : xfer
    task automatic wait_ref(output int n);
        for (n = 0; n < 4000 && settled !== 1'b1; n++) @(posedge clk);
    endtask : wait_ref
endmodule : adcct_host
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcct_regs.svh"
// ----------------------------------------
// Self-checking bench of the timer
// ----------------------------------------
module tb_top;
    import adcct_pkg::*;
    logic clk, nrst, ce;
    adcct_avs_req_t avs_req;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, irq, result_ready_n, conv_done, modulator_clk;
    logic turbo_mode, ref_settled, t;
    logic [2:0] rate_sel, r;
    logic [1:0] ref_sel, v;
    int err_count = 0, checks = 0, cyc = 0, t0, n;
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Short settle count keeps the run brief
    adcct_conv_timing #(.REF_SETTLE_NS(250)) i_adcct_conv_timing (
        .clk(clk), .nrst(nrst), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .result_ready_n(result_ready_n),
        .conv_done(conv_done), .modulator_clk(modulator_clk), .rate_sel(rate_sel),
        .ref_sel(ref_sel), .turbo_mode(turbo_mode), .ref_settled(ref_settled));
    adcct_host i_adcct_host (.clk(clk), .req(avs_req), .rdata(avs_readdata),
        .waitreq(avs_waitrequest), .settled(ref_settled));
    // ----------------------------------------
    // Expectations and compares
    // ----------------------------------------
    function automatic int exp_clk(input int osc, input logic trb);
        return (osc * 40000) / (trb ? 2048 : 1024);
    endfunction : exp_clk
    function automatic logic [31:0] ctrl_word(input logic [2:0] rr, input logic [1:0] vv,
                                              input logic tt);
        return {24'h000000, vv, rr, tt, 2'h0};
    endfunction : ctrl_word
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_eq
    // Slack covers oscillator jitter and start alignment
    task automatic chk_near(input int got, input int exp, input string m);
        checks++;
        if (got < exp - 60 || got > exp + 60) begin
            err_count++;
            $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask : chk_near
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_adcct_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        i_adcct_host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    // Ready must go high first, then fall
    task automatic wait_fall();
        for (n = 0; n < 60000 && result_ready_n !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 60000 && result_ready_n !== 1'b0; n++) @(posedge clk);
    endtask : wait_fall
    task automatic single(input logic trb, input int osc);
        wr(`ADCCT_OFS_CTRL, ctrl_word(3'h6, 2'h0, trb) | 32'h1);
        t0 = cyc;
        wait_fall();
        chk_near(cyc - t0, exp_clk(osc, trb), "single-shot time");
        $display("test single-shot done");
    endtask : single
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Watchdog sized above the four timed conversions
    initial begin
        repeat (130000) @(posedge clk);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        n = $urandom(3);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk_eq(ref_sel, 2'h0, "reference default");
        rd(`ADCCT_OFS_CTRL);
        chk_eq(q, 32'h0, "control reset");
        rd(`ADCCT_OFS_STAT);
        chk_eq(q & 32'h3, 32'h2, "status reset");
        rd(4'h2);
        chk_eq(q, 32'h0, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            r = 3'($urandom % 8);
            v = 2'($urandom % 4);
            t = 1'($urandom % 2);
            wr(`ADCCT_OFS_CTRL, ctrl_word(r, v, t));
            chk_eq({rate_sel, ref_sel, turbo_mode}, {r, v, t}, "control fields");
            rd(`ADCCT_OFS_CTRL);
            chk_eq(q, ctrl_word(r, v, t), "control readback");
        end
        $display("test config done");
        wr(`ADCCT_OFS_CTRL, ctrl_word(3'h6, 2'h1, 1'b0));
        wr(`ADCCT_OFS_CTRL, ctrl_word(3'h6, 2'h0, 1'b0));
        chk_eq(ref_settled, 1'b0, "settle restart");
        i_adcct_host.wait_ref(n);
        chk_eq(ref_settled, 1'b1, "reference settled");
        wr(`ADCCT_OFS_CTRL, 32'h00000101);
        rd(`ADCCT_OFS_STAT);
        chk_eq(q & 32'h1, 32'h0, "start refused in power-down");
        wr(`ADCCT_OFS_CTRL, ctrl_word(3'h6, 2'h0, 1'b0));
        chk_eq(ref_settled, 1'b0, "settle after power-down");
        i_adcct_host.wait_ref(n);
        chk_eq(ref_settled, 1'b1, "settled after power-down");
        $display("test reference done");
        wr(`ADCCT_OFS_ISTAT, 32'h3);
        wr(`ADCCT_OFS_IMASK, 32'h1);
        chk_eq(irq, 1'b0, "interrupt idle");
        single(1'b0, 1061);
        repeat (2) @(posedge clk);
        chk_eq(irq, 1'b1, "interrupt on done");
        wr(`ADCCT_OFS_IMASK, 32'h0);
        chk_eq(irq, 1'b0, "interrupt masked");
        wr(`ADCCT_OFS_ISTAT, 32'h1);
        wr(`ADCCT_OFS_IMASK, 32'h1);
        chk_eq(irq, 1'b0, "interrupt cleared");
        single(1'b1, 1065);
        wr(`ADCCT_OFS_CTRL, ctrl_word(3'h6, 2'h0, 1'b1) | 32'h3);
        t0 = cyc;
        wait_fall();
        chk_near(cyc - t0, exp_clk(1141, 1'b1), "first conversion");
        t0 = cyc;
        wait_fall();
        chk_near(cyc - t0, exp_clk(1036, 1'b1), "continuous period");
        $display("test continuous done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
